// ### logic/tsl_pkg.sv
/*
  constants of the temperature limit and alarm block: register indices,
  field positions, reset values and hysteresis offsets.
  assumes a serial slave elsewhere turns bus frames into register strobes.
*/
// Notes on behaviour
// - capability word reports timeout window, negative range, accuracy, alarm support; top byte zero.
// - resolution field codes 0.5, 0.25, 0.125, 0.0625 degree steps, matching conversion.
// - capability bit 7 says shutdown freezes (0) or clears (1) the alarm status.
// - clear bit still clears alarm during shutdown; nothing sets alarm during shutdown.
// - hysteresis field selects 0, 1.5, 3 or 6 degrees applied to thresholds.
// - shutdown stops converter and freezes temperature; resumes when cleared; zero at reset.
// - setting shutdown is ignored while any lock is set; clearing always works.
// - critical lock guards critical limit, alarm lock guards window limits; reset-only clear.
// - with any lock set, hysteresis, enable, polarity and mode ignore all writes.
// - critical-only bit cannot be set while alarm lock is set.
// - clear bit reads zero; clears latched alarm in interrupt mode, not above critical.
// - alarm status reads one whenever output asserted, regardless of polarity; gated by enable.
// - disabled output held inactive: released if active low, driven low if active high.
// - polarity zero makes open-drain output active low, one makes it active high.
// - mode zero is comparator behaviour, one is latched interrupt behaviour.
// - critical-only bit restricts alarm conditions to critical limit crossings.
// - limits are signed with sign at bit 12, 0.25 step; bits 15:13, 1:0 zero.
// - temperature in bits 12:0, 0.0625 step; bits below resolution read zero.
// - bit 15 at/above critical, 14 above high, 13 below low; unaffected by config.
// - interrupt mode latches on each window crossing until cleared; above critical stays set.
// - comparator asserts outside window, critical-only above critical, with hysteresis offsets.
// - shutdown keeps output state; otherwise limit writes re-evaluate at once.
// - eight 16-bit registers at indices 0 to 7.
// - every writable register resets to zero: output disabled, active low.
package tsl_pkg;
  localparam logic [2:0] REG_CAPABILITY = 3'h0;
  localparam logic [2:0] REG_CONFIG = 3'h1;
  localparam logic [2:0] REG_UPPER = 3'h2;
  localparam logic [2:0] REG_LOWER = 3'h3;
  localparam logic [2:0] REG_CRITICAL = 3'h4;
  localparam logic [2:0] REG_TEMPERATURE = 3'h5;
  localparam logic [2:0] REG_MAKER_ID = 3'h6;
  localparam logic [2:0] REG_DEVICE_ID = 3'h7;
  // configuration word fields
  localparam int CFG_MODE = 0;
  localparam int CFG_POL = 1;
  localparam int CFG_CRIT_ONLY = 2;
  localparam int CFG_ENABLE = 3;
  localparam int CFG_STATUS = 4;
  localparam int CFG_CLEAR = 5;
  localparam int CFG_ALARM_LOCK = 6;
  localparam int CFG_CRIT_LOCK = 7;
  localparam int CFG_SHUTDOWN = 8;
  localparam int CFG_HYSTERESIS_SELECT_LO = 9;
  // capability word fields
  localparam int CAP_ALARM_CRIT = 0;
  localparam int CAP_ACCURACY = 1;
  localparam int CAP_NEGATIVE = 2;
  localparam int CAP_RES_LO = 3;
  localparam int CAP_ADDR_HV = 5;
  localparam int CAP_TIMEOUT = 6;
  localparam int CAP_SD_BEHAV = 7;
  // temperature word fields
  localparam int TMP_CRIT = 15;
  localparam int TMP_HIGH = 14;
  localparam int TMP_LOW = 13;
  localparam logic [15:0] LIMIT_MASK = 16'h1ffc;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // hysteresis in 1/16 degree steps: 1.5, 3 and 6 degrees
  localparam logic [13:0] HYSTERESIS_SELECT_1P5 = 14'h0018;
  localparam logic [13:0] HYSTERESIS_SELECT_3 = 14'h0030;
  localparam logic [13:0] HYSTERESIS_SELECT_6 = 14'h0060;
  typedef enum logic [1:0] {
    TSL_RES_HALF = 2'b00,
    TSL_RES_QUARTER = 2'b01,
    TSL_RES_EIGHTH = 2'b10,
    TSL_RES_SIXTEENTH = 2'b11
  } tsl_res_e;
endpackage

// ### logic/tsl_core.sv
/*
  register file, limit comparison and open-drain alarm of the temperature sensor.
  assumes a serial slave on i_clk issues one-cycle register writes, and a converter
  on its own clock delivers one-cycle result strobes while o_conv_run is high.
*/
`timescale 1ns/10ps
module tsl_core
  import tsl_pkg::*;
#(
  parameter tsl_res_e RESOLUTION = TSL_RES_SIXTEENTH,
  parameter logic ACCURACY_CLASS = 1'b1,
  parameter logic TIMEOUT_WINDOW = 1'b1,
  parameter logic SHUTDOWN_CLEARS = 1'b0,
  parameter logic [15:0] MAKER_CODE = 16'h5a5a,  // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h0101  // arbitrary value
) (
  // system
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [2:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  // converter link
  input wire logic i_conv_clk,
  input wire logic i_conv_rst_n,
  input wire logic i_conv_valid,
  input wire logic [12:0] i_conv_data,
  output logic o_conv_run,
  // open-drain alarm pin
  output logic o_alarm_o,
  output logic o_alarm_oe_n
);

  logic [15:0] upper_window_limit;
  logic [15:0] lower_window_limit;
  logic [15:0] critical_limit;
  logic [12:0] temp_value;
  logic [2:0] trip_status;
  logic [1:0] hysteresis_select;
  logic sensor_shutdown, critical_limit_lock, alarm_lock;
  logic alarm_enable, critical_only_trigger, alarm_polarity, alarm_mode;
  logic alarm_latch, hi_st, lo_st, cr_st;
  logic lock_any, wr_cfg, clear_req;
  logic [15:0] capability_word;
  logic [15:0] configuration_word;
  logic [15:0] next_rdata;
  logic [12:0] res_mask;
  logic alarm_status;

  function automatic logic [12:0] res_to_mask(input tsl_res_e r);
    unique case (r)
      TSL_RES_HALF: res_to_mask = 13'h1ff8;
      TSL_RES_QUARTER: res_to_mask = 13'h1ffc;
      TSL_RES_EIGHTH: res_to_mask = 13'h1ffe;
      TSL_RES_SIXTEENTH: res_to_mask = 13'h1fff;
    endcase
  endfunction

  // converter domain: accept a result, hold it, toggle a request
  logic run_s1, run_s2, conv_req, ack_s1, ack_s2;
  logic req_seen;
  logic [12:0] conv_hold;
  always_ff @(posedge i_conv_clk) begin
    if (!i_conv_rst_n) begin
      run_s1 <= 1'b0;
      run_s2 <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      run_s1 <= o_conv_run;
      run_s2 <= run_s1;
      ack_s1 <= req_seen;
      ack_s2 <= ack_s1;
    end
  end

  // a result arriving while the last one is unacknowledged is dropped
  always_ff @(posedge i_conv_clk) begin
    if (!i_conv_rst_n) begin
      conv_req <= 1'b0;
      conv_hold <= 13'h0000;
    end else if (i_conv_valid && run_s2 && conv_req == ack_s2) begin
      conv_req <= ~conv_req;
      conv_hold <= i_conv_data;
    end
  end

  // system domain: detect the toggle; hold word is stable by then
  logic req_s1, req_s2, new_sample;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_seen <= 1'b0;
    end else begin
      req_s1 <= conv_req;
      req_s2 <= req_s1;
      req_seen <= req_s2;
    end
  end
  assign new_sample = req_s2 != req_seen;

  assign res_mask = res_to_mask(RESOLUTION);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      temp_value <= 13'h0000;
    end else if (new_sample && !sensor_shutdown) begin
      temp_value <= i_conv_data_masked(conv_hold);
    end
  end

  function automatic logic [12:0] i_conv_data_masked(input logic [12:0] d);
    i_conv_data_masked = d & res_to_mask(RESOLUTION);
  endfunction

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_conv_run <= 1'b0;
    end else begin
      o_conv_run <= !sensor_shutdown;
    end
  end

  // configuration writes
  assign lock_any = critical_limit_lock | alarm_lock;
  assign wr_cfg = i_reg_wr && i_reg_addr == REG_CONFIG;
  assign clear_req = wr_cfg && i_reg_wdata[CFG_CLEAR];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      critical_limit_lock <= 1'b0;
      alarm_lock <= 1'b0;
    end else if (wr_cfg) begin
      critical_limit_lock <= critical_limit_lock | i_reg_wdata[CFG_CRIT_LOCK];
      alarm_lock <= alarm_lock | i_reg_wdata[CFG_ALARM_LOCK];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sensor_shutdown <= 1'b0;
    end else if (wr_cfg && (!i_reg_wdata[CFG_SHUTDOWN] || !lock_any)) begin
      sensor_shutdown <= i_reg_wdata[CFG_SHUTDOWN];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hysteresis_select <= 2'b00;
      alarm_enable <= 1'b0;
      alarm_polarity <= 1'b0;
      alarm_mode <= 1'b0;
    end else if (wr_cfg && !lock_any) begin
      hysteresis_select <= i_reg_wdata[CFG_HYSTERESIS_SELECT_LO+:2];
      alarm_enable <= i_reg_wdata[CFG_ENABLE];
      alarm_polarity <= i_reg_wdata[CFG_POL];
      alarm_mode <= i_reg_wdata[CFG_MODE];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      critical_only_trigger <= 1'b0;
    end else if (wr_cfg && (!i_reg_wdata[CFG_CRIT_ONLY] || !alarm_lock)) begin
      critical_only_trigger <= i_reg_wdata[CFG_CRIT_ONLY];
    end
  end

  // limit registers; low two bits and top three bits never stored
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      upper_window_limit <= RESET_WORD;
      lower_window_limit <= RESET_WORD;
    end else if (i_reg_wr && !alarm_lock) begin
      if (i_reg_addr == REG_UPPER) begin
        upper_window_limit <= i_reg_wdata & LIMIT_MASK;
      end
      if (i_reg_addr == REG_LOWER) begin
        lower_window_limit <= i_reg_wdata & LIMIT_MASK;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      critical_limit <= RESET_WORD;
    end else if (i_reg_wr && i_reg_addr == REG_CRITICAL && !critical_limit_lock) begin
      critical_limit <= i_reg_wdata & LIMIT_MASK;
    end
  end

  // comparison; limits share the temperature scaling, 1/16 degree per count
  logic signed [13:0] t_s, hi_s, lo_s, cr_s, hy_s;
  assign t_s = $signed({temp_value[12], temp_value});
  assign hi_s = $signed({upper_window_limit[12], upper_window_limit[12:0]});
  assign lo_s = $signed({lower_window_limit[12], lower_window_limit[12:0]});
  assign cr_s = $signed({critical_limit[12], critical_limit[12:0]});
  always_comb begin
    unique case (hysteresis_select)
      2'b00: hy_s = 14'sh0000;
      2'b01: hy_s = $signed(HYSTERESIS_SELECT_1P5);
      2'b10: hy_s = $signed(HYSTERESIS_SELECT_3);
      2'b11: hy_s = $signed(HYSTERESIS_SELECT_6);
    endcase
  end

  // raw trip bits, independent of alarm setup
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      trip_status <= 3'b000;
    end else begin
      trip_status <= {t_s >= cr_s, t_s > hi_s, t_s < lo_s};
    end
  end

  // hysteretic states, re-evaluated every cycle outside shutdown so limit writes act at once
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hi_st <= 1'b0;
      lo_st <= 1'b0;
      cr_st <= 1'b0;
    end else if (!sensor_shutdown) begin
      hi_st <= hi_st ? (t_s > hi_s - hy_s) : (t_s > hi_s);
      lo_st <= lo_st ? (t_s < lo_s + hy_s) : (t_s < lo_s);
      cr_st <= cr_st ? (t_s >= cr_s - hy_s) : (t_s >= cr_s);
    end
  end

  logic next_hi, next_lo, next_cr, window_cross, cond;
  assign next_hi = hi_st ? (t_s > hi_s - hy_s) : (t_s > hi_s);
  assign next_lo = lo_st ? (t_s < lo_s + hy_s) : (t_s < lo_s);
  assign next_cr = cr_st ? (t_s >= cr_s - hy_s) : (t_s >= cr_s);
  // a crossing is any change of a watched state, in either direction
  assign window_cross = critical_only_trigger ? (next_cr != cr_st) :
                        (next_hi != hi_st) || (next_lo != lo_st) || (next_cr != cr_st);
  assign cond = critical_only_trigger ? cr_st : (hi_st | lo_st | cr_st);

  // alarm latch; set beats clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      alarm_latch <= 1'b0;
    end else if (sensor_shutdown) begin
      if (clear_req || (SHUTDOWN_CLEARS && wr_cfg)) begin
        alarm_latch <= 1'b0;
      end
    end else if (wr_cfg && i_reg_wdata[CFG_SHUTDOWN] && !lock_any && SHUTDOWN_CLEARS) begin
      alarm_latch <= 1'b0;
    end else if (!alarm_mode) begin
      alarm_latch <= cond;
    end else if (cr_st || window_cross) begin
      alarm_latch <= 1'b1;
    end else if (clear_req) begin
      alarm_latch <= 1'b0;
    end
  end

  assign alarm_status = alarm_latch & alarm_enable;

  // open-drain: drive low when asserted-low, or when idle with active-high polarity
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_alarm_oe_n <= 1'b1;
    end else begin
      o_alarm_oe_n <= (alarm_status ~^ alarm_polarity) ? 1'b1 : 1'b0;
    end
  end
  assign o_alarm_o = 1'b0;

  // register read
  always_comb begin
    capability_word = 16'h0000;
    capability_word[CAP_ALARM_CRIT] = 1'b1;
    capability_word[CAP_ACCURACY] = ACCURACY_CLASS;
    capability_word[CAP_NEGATIVE] = 1'b1;
    capability_word[CAP_RES_LO+:2] = RESOLUTION;
    capability_word[CAP_ADDR_HV] = 1'b1;
    capability_word[CAP_TIMEOUT] = TIMEOUT_WINDOW;
    capability_word[CAP_SD_BEHAV] = SHUTDOWN_CLEARS;
    configuration_word = 16'h0000;
    configuration_word[CFG_HYSTERESIS_SELECT_LO+:2] = hysteresis_select;
    configuration_word[CFG_SHUTDOWN] = sensor_shutdown;
    configuration_word[CFG_CRIT_LOCK] = critical_limit_lock;
    configuration_word[CFG_ALARM_LOCK] = alarm_lock;
    configuration_word[CFG_STATUS] = alarm_status;
    configuration_word[CFG_ENABLE] = alarm_enable;
    configuration_word[CFG_CRIT_ONLY] = critical_only_trigger;
    configuration_word[CFG_POL] = alarm_polarity;
    configuration_word[CFG_MODE] = alarm_mode;
  end

  always_comb begin
    unique case (i_reg_addr)
      REG_CAPABILITY: next_rdata = capability_word;
      REG_CONFIG: next_rdata = configuration_word;
      REG_UPPER: next_rdata = upper_window_limit;
      REG_LOWER: next_rdata = lower_window_limit;
      REG_CRITICAL: next_rdata = critical_limit;
      REG_TEMPERATURE: next_rdata = {trip_status, temp_value & res_mask};
      REG_MAKER_ID: next_rdata = MAKER_CODE;
      REG_DEVICE_ID: next_rdata = DEVICE_CODE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 16'h0000;
    end else begin
      o_reg_rdata <= next_rdata;
    end
  end

  // checks
  shutdown_set_locked_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_cfg && i_reg_wdata[CFG_SHUTDOWN] && lock_any && !sensor_shutdown |=> !sensor_shutdown)
    else $error("shutdown set while locked");
  lock_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !$fell(critical_limit_lock) && !$fell(alarm_lock))
    else $error("lock bit cleared");
  limit_lock_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    alarm_lock |=> $stable(upper_window_limit) && $stable(lower_window_limit))
    else $error("window limit changed under lock");
  cfg_lock_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    lock_any |=> $stable(hysteresis_select) && $stable(alarm_mode) && $stable(alarm_polarity))
    else $error("locked field changed");
  clear_reads_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_reg_addr) == REG_CONFIG |-> o_reg_rdata[CFG_CLEAR] == 1'b0)
    else $error("clear bit read as one");
  disabled_pin_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !alarm_enable ##1 !alarm_enable |-> o_alarm_oe_n == !$past(alarm_polarity))
    else $error("disabled pin not inactive");
  crit_holds_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    alarm_mode && cr_st && !sensor_shutdown ##1 !sensor_shutdown |-> alarm_latch)
    else $error("alarm cleared above critical");
  comparator_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !alarm_mode && !sensor_shutdown && !wr_cfg |=> alarm_latch == $past(cond))
    else $error("comparator output wrong");
  freeze_temp_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sensor_shutdown ##1 sensor_shutdown |-> $stable(temp_value))
    else $error("temperature moved in shutdown");
  no_set_shutdown_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sensor_shutdown && !alarm_latch |=> !alarm_latch)
    else $error("alarm set during shutdown");

endmodule  // tsl_core

// ### tb/tsl_conv_model.sv
/*
  converter stand-in on its own clock: one result strobe per request toggle while running or forced.
  assumes the bench toggles i_req_tgl once per result and spaces requests widely.
*/
`timescale 1ns/10ps
module tsl_conv_model (
  // converter clock
  input wire logic i_conv_clk,
  // run from the core, other control from the bench
  input wire logic i_run,
  input wire logic i_force,
  input wire logic i_req_tgl,
  input wire logic [12:0] i_value,
  // result link
  output logic o_valid,
  output logic [12:0] o_data
);
  logic [2:0] sync;
  initial begin
    sync = 3'h0;
    o_valid = 1'b0;
    o_data = 13'h0000;
  end
  always @(posedge i_conv_clk) begin
    sync <= {sync[1:0], i_req_tgl};
    o_valid <= 1'b0;
    // data churns between strobes so a stale value is never mistaken for a result
    o_data <= ~o_data;
    // a stopped converter delivers nothing, unless the bench insists
    if ((sync[2] != sync[1]) && (i_run || i_force)) begin
      o_valid <= 1'b1;
      o_data <= i_value;
    end
  end
endmodule // tsl_conv_model

// ### tb/tb.sv
/*
  self-checking bench of the temperature limit and alarm block.
  assumes the converter model drives the link on a 12 ns clock.
*/
`timescale 1ns/10ps
module tb;
  import tsl_pkg::*;
  logic i_clk = 1'b0;
  logic conv_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic wr = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic conv_valid;
  logic conv_run;
  logic alarm_o;
  logic alarm_oe_n;
  logic [12:0] conv_data;
  logic force_conv = 1'b0;
  logic req_tgl = 1'b0;
  logic [12:0] value = 13'h0000;
  int n_fail = 0;
  int checked = 0;
  always #5 i_clk = ~i_clk;
  always #6 conv_clk = ~conv_clk;
  tsl_core #(.MAKER_CODE(16'h3c3c), .DEVICE_CODE(16'h0202)) tsl_core_inst (  // arbitrary codes
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_conv_clk(conv_clk),
    .i_conv_rst_n(i_rst_n), .i_conv_valid(conv_valid), .i_conv_data(conv_data),
    .o_conv_run(conv_run), .o_alarm_o(alarm_o), .o_alarm_oe_n(alarm_oe_n));
  tsl_conv_model tsl_conv_model_inst (
    .i_conv_clk(conv_clk), .i_run(conv_run), .i_force(force_conv),
    .i_req_tgl(req_tgl), .i_value(value), .o_valid(conv_valid), .o_data(conv_data));
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wrr(input logic [2:0] a, input logic [15:0] d);
    @(negedge i_clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge i_clk);
    wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    addr = a;
    repeat (2) @(negedge i_clk);
    chk16(rdata, exp);
  endtask
  // latch, then status, then the registered pin: a few cycles of slack
  task automatic pin(input logic exp);
    repeat (4) @(negedge i_clk);
    chk1(alarm_oe_n, exp);
  endtask
  // the result crosses domains and the compares follow; 30 cycles covers it
  task automatic conv(input logic [12:0] v);
    @(negedge i_clk);
    value = v;
    req_tgl = ~req_tgl;
    repeat (30) @(negedge i_clk);
  endtask
  task automatic t_reset;
    rd(REG_CAPABILITY, 16'h007f);
    rd(REG_CONFIG, 16'h0000);
    rd(REG_UPPER, 16'h0000);
    rd(REG_MAKER_ID, 16'h3c3c);
    rd(REG_DEVICE_ID, 16'h0202);
    chk1(alarm_oe_n, 1'b1);
    chk1(alarm_o, 1'b0);
    chk1(conv_run, 1'b1);
  endtask
  task automatic t_window;
    wrr(REG_UPPER, 16'hffff);
    rd(REG_UPPER, 16'h1ffc);
    wrr(REG_UPPER, 16'h0190);
    wrr(REG_LOWER, 16'h0000);
    wrr(REG_CRITICAL, 16'h0320);
    conv(13'h01a0);
    rd(REG_TEMPERATURE, 16'h41a0);
    conv(13'h1ff0);
    rd(REG_TEMPERATURE, 16'h3ff0);
    wrr(REG_CONFIG, 16'h0002);
    pin(1'b0);
    rd(REG_CONFIG, 16'h0002);
  endtask
  task automatic t_comp;
    wrr(REG_CONFIG, 16'h0008);
    pin(1'b0);
    rd(REG_CONFIG, 16'h0018);
    wrr(REG_CONFIG, 16'h000a);
    pin(1'b1);
    rd(REG_CONFIG, 16'h001a);
    wrr(REG_CONFIG, 16'h002a);
    rd(REG_CONFIG, 16'h001a);
    wrr(REG_CONFIG, 16'h000e);
    pin(1'b0);
    rd(REG_CONFIG, 16'h000e);
    wrr(REG_CONFIG, 16'h000a);
    pin(1'b1);
    wrr(REG_LOWER, 16'h1fe0);
    pin(1'b0);
  endtask
  task automatic t_hysteresis_select;
    wrr(REG_CONFIG, 16'h0208);
    conv(13'h01a0);
    chk1(alarm_oe_n, 1'b0);
    conv(13'h0180);
    rd(REG_TEMPERATURE, 16'h0180);
    chk1(alarm_oe_n, 1'b0);
    conv(13'h0170);
    chk1(alarm_oe_n, 1'b1);
  endtask
  task automatic t_int;
    wrr(REG_CONFIG, 16'h0009);
    conv(13'h01a0);
    chk1(alarm_oe_n, 1'b0);
    conv(13'h0170);
    chk1(alarm_oe_n, 1'b0);
    wrr(REG_CONFIG, 16'h0029);
    pin(1'b1);
    rd(REG_CONFIG, 16'h0009);
    conv(13'h0330);
    rd(REG_TEMPERATURE, 16'hc330);
    wrr(REG_CONFIG, 16'h0029);
    pin(1'b0);
    rd(REG_CONFIG, 16'h0019);
  endtask
  task automatic t_sd;
    wrr(REG_CONFIG, 16'h0109);
    rd(REG_CONFIG, 16'h0119);
    chk1(conv_run, 1'b0);
    pin(1'b0);
    force_conv = 1'b1;
    conv(13'h0100);
    force_conv = 1'b0;
    rd(REG_TEMPERATURE, 16'hc330);
    wrr(REG_CONFIG, 16'h0129);
    pin(1'b1);
    rd(REG_CONFIG, 16'h0109);
    wrr(REG_CONFIG, 16'h0009);
    rd(REG_CONFIG, 16'h0019);
    chk1(conv_run, 1'b1);
  endtask
  task automatic t_lock;
    conv(13'h0100);
    wrr(REG_CONFIG, 16'h0029);
    wrr(REG_CONFIG, 16'h0049);
    rd(REG_CONFIG, 16'h0049);
    wrr(REG_UPPER, 16'h0100);
    rd(REG_UPPER, 16'h0190);
    wrr(REG_CONFIG, 16'h074e);
    rd(REG_CONFIG, 16'h0049);
    chk1(conv_run, 1'b1);
    wrr(REG_CRITICAL, 16'h0200);
    rd(REG_CRITICAL, 16'h0200);
    wrr(REG_CONFIG, 16'h00c9);
    wrr(REG_CRITICAL, 16'h0300);
    rd(REG_CRITICAL, 16'h0200);
    wrr(REG_CONFIG, 16'h0000);
    rd(REG_CONFIG, 16'h00c9);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // the whole run needs about 460 cycles
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_reset();
    t_window();
    t_comp();
    t_hysteresis_select();
    t_int();
    t_sd();
    t_lock();
    end_sim();
  end
endmodule // tb
